// [common/ucr_pkg.sv]
// Package for the indirect USB register map and clock recovery
package ucr_pkg;
    localparam logic [5:0] ADR_FUNC_ADDR = 6'h00;
    localparam logic [5:0] ADR_POWER = 6'h01;
    localparam logic [5:0] ADR_IN_FLAGS = 6'h02;
    localparam logic [5:0] ADR_OUT_FLAGS = 6'h04;
    localparam logic [5:0] ADR_CM_FLAGS = 6'h06;
    localparam logic [5:0] ADR_IN_EN = 6'h07;
    localparam logic [5:0] ADR_OUT_EN = 6'h09;
    localparam logic [5:0] ADR_CM_EN = 6'h0B;
    localparam logic [5:0] ADR_FRAME_LO = 6'h0C;
    localparam logic [5:0] ADR_FRAME_HI = 6'h0D;
    localparam logic [5:0] ADR_EP_SEL = 6'h0E;
    localparam logic [5:0] ADR_CLK_REC = 6'h0F;
    localparam logic [5:0] ADR_EP0_CSR = 6'h11;
    localparam logic [5:0] ADR_IN_CSR_HI = 6'h12;
    localparam logic [5:0] ADR_IN_CSR_LO = 6'h13;
    localparam logic [5:0] ADR_OUT_CSR_LO = 6'h14;
    localparam logic [5:0] ADR_OUT_CSR_HI = 6'h15;
    localparam logic [5:0] ADR_EP0_CNT = 6'h16;
    localparam logic [5:0] ADR_OUT_CNT_HI = 6'h17;
    localparam logic [5:0] ADR_OUT_CNT_LO = 6'h18;
    localparam logic [5:0] ADR_FIFO_BASE = 6'h20;
    localparam logic [5:0] ADR_FIFO_LAST = 6'h23;
    localparam logic [7:0] CLK_REC_RESET = 8'h09;
    localparam logic [7:0] SEL_MASK = 8'h0F;
    localparam logic [3:0] EP_LAST = 4'h3;
    localparam int CR_ENABLE_BIT = 7;
    localparam int CR_SINGLE_BIT = 6;
    localparam int CR_LOW_BIT = 5;
    localparam int ADR_BUSY_BIT = 7;
    localparam int ADR_AUTO_BIT = 6;
    localparam logic [7:0] TRIM_MID = 8'h80;
    localparam logic [7:0] TRIM_STEP_FINE = 8'h01;
    localparam logic [7:0] TRIM_STEP_COARSE = 8'h04;
    localparam int SYS_MHZ = 200;
    localparam int FS_BIT_MHZ_X10 = 120;
    localparam int LS_BIT_MHZ_X10 = 15;
    localparam int FS_FRAME_BITS = 12000;
    localparam int LS_FRAME_BITS = 1500;
    localparam logic [7:0] READ_LATENCY = 8'h02;
    typedef struct packed {
        logic enable;
        logic single_step;
        logic low_speed;
        logic full_speed;
    } ucr_rec_cfg_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_BUSY = 3'b010,
        ST_DONE = 3'b100
    } ucr_rd_state_t;
endpackage : ucr_pkg

// [logic/ucr_clock_recovery.sv]
// Oscillator trim loop driven by received frame markers
`timescale 1ns/1ps
module ucr_clock_recovery import ucr_pkg::*; #(
    parameter int CNT_W = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire ucr_rec_cfg_t cfg,
    input wire logic frame_mark,
    output logic [7:0] trim,
    output logic locked
);
    localparam logic [CNT_W-1:0] FS_TARGET =
        CNT_W'(FS_FRAME_BITS * 4);
    localparam logic [CNT_W-1:0] LS_TARGET =
        CNT_W'(LS_FRAME_BITS * 32);
    logic [CNT_W-1:0] period_reg;
    logic seen_reg;
    logic [CNT_W-1:0] target;
    logic [7:0] step;
    // Low speed frames keep-alive timing; full speed targets 1 ms
    assign target = cfg.low_speed ? LS_TARGET : FS_TARGET;
    // Single step moves one code per frame, robust but slow
    assign step = cfg.single_step ? TRIM_STEP_FINE : TRIM_STEP_COARSE;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            period_reg <= '0;
            seen_reg <= 1'b0;
        end else if (!cfg.enable || frame_mark) begin
            period_reg <= '0;
            seen_reg <= cfg.enable;
        end else if (period_reg != '1) begin
            period_reg <= period_reg + CNT_W'(1);
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trim <= TRIM_MID;
            locked <= 1'b0;
        end else if (cfg.enable && frame_mark && seen_reg) begin // R5
            if (period_reg > target && trim != 8'hFF) begin
                trim <= (8'hFF - trim < step) ? 8'hFF : trim + step;
                locked <= 1'b0;
            end else if (period_reg < target && trim != 8'h00) begin
                trim <= (trim < step) ? 8'h00 : trim - step;
                locked <= 1'b0;
            end else begin
                locked <= 1'b1;
            end
        end else if (!cfg.enable) begin
            locked <= 1'b0;
        end
    end
endmodule : ucr_clock_recovery

// [logic/ucr_register_map.sv]
// Indirectly addressed USB core register map with clock recovery
// Summary of operation
// R1: Endpoint select steers indexed registers, 0-3
// R2: Low speed core clock is 6 MHz
// R3: Full speed core clock is 48 MHz
// R4: Speed bit selects full or low speed
// R5: Recovery trims oscillator from received stream
// R6: Recovery advised for multiplier or divided oscillator
// R7: Low speed recovery needs low speed bit set
// R8: Low speed recovery usually unnecessary
// R9: Single step calibration option available
// R10: Interrupt flags at 0x02, 0x04, 0x06
// R11: Interrupt enables at 0x07, 0x09, 0x0B
// R12: Common registers address, power, frame number
// R13: Indexed endpoint control/status follow selection
// R14: Endpoint 0 received count readable
// R15: OUT byte count readable, high at 0x17
// R16: Access through address and data ports
// R17: Software selects endpoint before indexed access
// R18: Reserved select values select no endpoint
`timescale 1ns/1ps
module ucr_register_map import ucr_pkg::*; #(
    parameter int NUM_EP = 4
) (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic ADDR_WR,
    input wire logic [7:0] ADDR_WDATA,
    input wire logic DATA_WR,
    input wire logic DATA_RD,
    input wire logic [7:0] DATA_WDATA,
    input wire logic SPEED_SELECT,
    input wire logic FRAME_MARK,
    input wire logic [10:0] FRAME_NUMBER,
    input wire logic [7:0] IN_EVENTS,
    input wire logic [7:0] OUT_EVENTS,
    input wire logic [7:0] CM_EVENTS,
    input wire logic [7:0] EP0_RX_COUNT,
    input wire logic [15:0] OUT_RX_COUNT,
    input wire logic [7:0] FIFO_RDATA,
    output logic [7:0] ADDR_RDATA,
    output logic [7:0] DATA_RDATA,
    output logic [7:0] OSC_TRIM,
    output logic RECOVERY_LOCKED,
    output logic FULL_SPEED,
    output logic FIFO_WR,
    output logic FIFO_RD,
    output logic [1:0] FIFO_EP,
    output logic [7:0] FIFO_WDATA,
    output logic [1:0] SELECTED_EP,
    output logic SELECT_VALID
);
    logic [1:0] speed_sync_reg;
    logic [1:0] frame_sync_reg;
    logic frame_prev_reg;
    logic frame_pulse;
    logic [5:0] target_reg;
    logic auto_reg;
    ucr_rd_state_t rd_state_reg;
    logic [7:0] rd_wait_reg;
    logic [7:0] rd_data_reg;
    logic [7:0] func_addr_reg;
    logic [7:0] power_reg;
    logic [7:0] in_flags_reg;
    logic [7:0] out_flags_reg;
    logic [7:0] cm_flags_reg;
    logic [7:0] in_en_reg;
    logic [7:0] out_en_reg;
    logic [7:0] cm_en_reg;
    logic [3:0] sel_reg;
    logic [7:0] clk_rec_reg;
    logic [7:0] ep0_csr_reg;
    logic [7:0] in_csr_hi_reg [NUM_EP];
    logic [7:0] in_csr_lo_reg [NUM_EP];
    logic [7:0] out_csr_lo_reg [NUM_EP];
    logic [7:0] out_csr_hi_reg [NUM_EP];
    logic sel_ok;
    logic [1:0] sel_ep;
    logic start_rd;
    logic [7:0] rd_next;
    logic [7:0] trim_w;
    logic locked_w;
    ucr_rec_cfg_t rec_cfg;
    logic [5:0] acc_target;
    logic [1:0] up_cnt_reg;

    function automatic logic is_fifo(input logic [5:0] a);
        is_fifo = (a >= ADR_FIFO_BASE) && (a <= ADR_FIFO_LAST);
    endfunction : is_fifo

    // Write clears only the bits written as one; new events win
    function automatic logic [7:0] flag_next(input logic [7:0] cur,
            input logic [7:0] ev, input logic clr,
            input logic [7:0] wd);
        flag_next = (clr ? (cur & ~wd) : cur) | ev;
    endfunction : flag_next

    // Pins from outside the clock domain go through two stages
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            speed_sync_reg <= 2'b00;
            frame_sync_reg <= 2'b00;
            frame_prev_reg <= 1'b0;
        end else begin
            speed_sync_reg <= {speed_sync_reg[0], SPEED_SELECT};
            frame_sync_reg <= {frame_sync_reg[0], FRAME_MARK};
            frame_prev_reg <= frame_sync_reg[1];
        end
    end
    assign frame_pulse = frame_sync_reg[1] && !frame_prev_reg;

    assign sel_ok = (sel_reg <= EP_LAST); // R18
    assign sel_ep = sel_reg[1:0]; // R1

    // Address port: busy, auto read and target address
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            target_reg <= '0;
            auto_reg <= 1'b0;
        end else if (ADDR_WR) begin
            target_reg <= ADDR_WDATA[5:0]; // R16
            auto_reg <= ADDR_WDATA[ADR_AUTO_BIT];
        end
    end
    assign start_rd = (ADDR_WR && ADDR_WDATA[ADR_BUSY_BIT])
        || (DATA_RD && auto_reg && rd_state_reg != ST_BUSY);
    // Read launched from the address port acts on the new target
    assign acc_target = ADDR_WR ? ADDR_WDATA[5:0] : target_reg;

    // Reads go through a short busy phase before data is valid
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rd_state_reg <= ST_IDLE;
            rd_wait_reg <= '0;
        end else begin
            case (rd_state_reg)
                ST_IDLE, ST_DONE: begin
                    if (start_rd) begin
                        rd_state_reg <= ST_BUSY;
                        rd_wait_reg <= READ_LATENCY;
                    end
                end
                ST_BUSY: begin
                    if (rd_wait_reg == 8'h01) begin
                        rd_state_reg <= ST_DONE;
                    end
                    rd_wait_reg <= rd_wait_reg - 8'h01;
                end
                default: begin
                    rd_state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        rd_next = 8'h00;
        case (target_reg) // R16
            ADR_FUNC_ADDR: rd_next = func_addr_reg; // R12
            ADR_POWER: rd_next = power_reg; // R12
            ADR_IN_FLAGS: rd_next = in_flags_reg; // R10
            ADR_OUT_FLAGS: rd_next = out_flags_reg; // R10
            ADR_CM_FLAGS: rd_next = cm_flags_reg; // R10
            ADR_IN_EN: rd_next = in_en_reg; // R11
            ADR_OUT_EN: rd_next = out_en_reg; // R11
            ADR_CM_EN: rd_next = cm_en_reg; // R11
            ADR_FRAME_LO: rd_next = FRAME_NUMBER[7:0]; // R12
            ADR_FRAME_HI: rd_next = {5'h00, FRAME_NUMBER[10:8]}; // R12
            ADR_EP_SEL: rd_next = {4'h0, sel_reg};
            ADR_CLK_REC: rd_next = clk_rec_reg;
            ADR_EP0_CSR: rd_next = ep0_csr_reg; // R13
            ADR_IN_CSR_HI: rd_next = sel_ok ? in_csr_hi_reg[sel_ep] : 8'h00;
            ADR_IN_CSR_LO: rd_next = sel_ok ? in_csr_lo_reg[sel_ep] : 8'h00;
            ADR_OUT_CSR_LO: rd_next = sel_ok ? out_csr_lo_reg[sel_ep] : 8'h00;
            ADR_OUT_CSR_HI: rd_next = sel_ok ? out_csr_hi_reg[sel_ep] : 8'h00;
            ADR_EP0_CNT: rd_next = EP0_RX_COUNT; // R14
            ADR_OUT_CNT_HI: rd_next = OUT_RX_COUNT[15:8]; // R15
            ADR_OUT_CNT_LO: rd_next = OUT_RX_COUNT[7:0]; // R15
            default: rd_next = is_fifo(target_reg) ? FIFO_RDATA : 8'h00;
        endcase
    end

    // Data latched when the busy phase ends
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rd_data_reg <= 8'h00;
        end else if (rd_state_reg == ST_BUSY && rd_wait_reg == 8'h01) begin
            rd_data_reg <= rd_next;
        end
    end

    // FIFO port strobes; read unloads at start of busy phase
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            FIFO_WR <= 1'b0;
            FIFO_RD <= 1'b0;
            FIFO_EP <= 2'b00;
            FIFO_WDATA <= 8'h00;
        end else begin
            FIFO_WR <= DATA_WR && is_fifo(target_reg);
            FIFO_RD <= start_rd && rd_state_reg != ST_BUSY
                && is_fifo(acc_target); // R16
            FIFO_EP <= acc_target[1:0];
            FIFO_WDATA <= DATA_WDATA;
        end
    end

    // Common and interrupt registers
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            func_addr_reg <= 8'h00;
            power_reg <= 8'h00;
            in_en_reg <= 8'h00;
            out_en_reg <= 8'h00;
            cm_en_reg <= 8'h00;
            sel_reg <= 4'h0;
            clk_rec_reg <= CLK_REC_RESET;
            ep0_csr_reg <= 8'h00;
        end else if (DATA_WR) begin
            case (target_reg)
                ADR_FUNC_ADDR: func_addr_reg <= DATA_WDATA; // R12
                ADR_POWER: power_reg <= DATA_WDATA; // R12
                ADR_IN_EN: in_en_reg <= DATA_WDATA; // R11
                ADR_OUT_EN: out_en_reg <= DATA_WDATA; // R11
                ADR_CM_EN: cm_en_reg <= DATA_WDATA; // R11
                ADR_EP_SEL: sel_reg <= DATA_WDATA[3:0]; // R1
                ADR_CLK_REC: clk_rec_reg <= DATA_WDATA; // R9
                ADR_EP0_CSR: ep0_csr_reg <= DATA_WDATA; // R13
                default: ;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            in_flags_reg <= 8'h00;
            out_flags_reg <= 8'h00;
            cm_flags_reg <= 8'h00;
        end else begin // R10
            in_flags_reg <= flag_next(in_flags_reg, IN_EVENTS,
                DATA_WR && target_reg == ADR_IN_FLAGS, DATA_WDATA);
            out_flags_reg <= flag_next(out_flags_reg, OUT_EVENTS,
                DATA_WR && target_reg == ADR_OUT_FLAGS, DATA_WDATA);
            cm_flags_reg <= flag_next(cm_flags_reg, CM_EVENTS,
                DATA_WR && target_reg == ADR_CM_FLAGS, DATA_WDATA);
        end
    end

    // Indexed endpoint registers; reserved select writes nothing
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            for (int i = 0; i < NUM_EP; i++) begin
                in_csr_hi_reg[i] <= 8'h00;
                in_csr_lo_reg[i] <= 8'h00;
                out_csr_lo_reg[i] <= 8'h00;
                out_csr_hi_reg[i] <= 8'h00;
            end
        end else if (DATA_WR && sel_ok) begin // R13
            case (target_reg)
                ADR_IN_CSR_HI: in_csr_hi_reg[sel_ep] <= DATA_WDATA;
                ADR_IN_CSR_LO: in_csr_lo_reg[sel_ep] <= DATA_WDATA;
                ADR_OUT_CSR_LO: out_csr_lo_reg[sel_ep] <= DATA_WDATA;
                ADR_OUT_CSR_HI: out_csr_hi_reg[sel_ep] <= DATA_WDATA;
                default: ;
            endcase
        end
    end

    assign rec_cfg.enable = clk_rec_reg[CR_ENABLE_BIT]; // R5
    assign rec_cfg.single_step = clk_rec_reg[CR_SINGLE_BIT]; // R9
    assign rec_cfg.low_speed = clk_rec_reg[CR_LOW_BIT]; // R7
    assign rec_cfg.full_speed = speed_sync_reg[1]; // R4

    ucr_clock_recovery #(
        .CNT_W(16)
    ) u_rec (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .cfg(rec_cfg),
        .frame_mark(frame_pulse),
        .trim(trim_w),
        .locked(locked_w)
    );

    // Outputs registered
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ADDR_RDATA <= 8'h00;
            DATA_RDATA <= 8'h00;
            OSC_TRIM <= TRIM_MID;
            RECOVERY_LOCKED <= 1'b0;
            FULL_SPEED <= 1'b0;
            SELECTED_EP <= 2'b00;
            SELECT_VALID <= 1'b1;
        end else begin
            ADDR_RDATA <= {rd_state_reg == ST_BUSY || start_rd, auto_reg,
                target_reg};
            DATA_RDATA <= rd_data_reg;
            OSC_TRIM <= trim_w; // R5
            RECOVERY_LOCKED <= locked_w;
            FULL_SPEED <= speed_sync_reg[1]; // R4
            SELECTED_EP <= sel_ep; // R1
            SELECT_VALID <= sel_ok; // R18
        end
    end

    // Settled cycles since reset, so history checks skip reset values
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            up_cnt_reg <= '0;
        end else if (up_cnt_reg != '1) begin
            up_cnt_reg <= up_cnt_reg + 2'h1;
        end
    end

    a_flag_set_wins: assert property (@(posedge SYS_CLK) // R10
        disable iff (!RESET_N) IN_EVENTS[0] |=> in_flags_reg[0])
        else $error("in flag event lost");
    a_enable_write: assert property (@(posedge SYS_CLK) // R11
        disable iff (!RESET_N) DATA_WR && target_reg == ADR_CM_EN
        |=> cm_en_reg == $past(DATA_WDATA))
        else $error("common enable not written");
    a_select_valid: assert property (@(posedge SYS_CLK) // R18
        disable iff (!RESET_N) DATA_WR && target_reg == ADR_EP_SEL
        |=> ##1 SELECT_VALID == ($past(DATA_WDATA[3:0], 2) <= EP_LAST))
        else $error("select validity wrong");
    a_index_sel: assert property (@(posedge SYS_CLK) // R1
        disable iff (!RESET_N) SELECTED_EP == $past(sel_reg[1:0]))
        else $error("selected endpoint mismatch");
    a_speed_follow: assert property (@(posedge SYS_CLK) // R4
        disable iff (!RESET_N) up_cnt_reg == '1
        |-> FULL_SPEED == $past(SPEED_SELECT, 3))
        else $error("speed output not following pin");
    sequence s_read_start;
        ADDR_WR && ADDR_WDATA[ADR_BUSY_BIT] && rd_state_reg != ST_BUSY;
    endsequence
    a_read_done: assert property (@(posedge SYS_CLK) // R16
        disable iff (!RESET_N) s_read_start |-> ##3 rd_state_reg == ST_DONE)
        else $error("read busy phase wrong length");
    a_fifo_read_ep: assert property (@(posedge SYS_CLK) // R16
        disable iff (!RESET_N) ADDR_WR && ADDR_WDATA[ADR_BUSY_BIT]
        && rd_state_reg != ST_BUSY && is_fifo(ADDR_WDATA[5:0])
        |=> FIFO_RD && FIFO_EP == $past(ADDR_WDATA[1:0]))
        else $error("fifo read strobe on wrong endpoint");
    a_trim_hold: assert property (@(posedge SYS_CLK) // R5
        disable iff (!RESET_N) !rec_cfg.enable |=> $stable(trim_w))
        else $error("trim moved while disabled");
    a_ep0_count: assert property (@(posedge SYS_CLK) // R14
        disable iff (!RESET_N) target_reg == ADR_EP0_CNT
        && rd_state_reg == ST_BUSY && rd_wait_reg == 8'h01
        |=> rd_data_reg == $past(EP0_RX_COUNT))
        else $error("ep0 count not returned");
endmodule : ucr_register_map

// [verification/ucr_host_model.sv]
// Bus host model that sends frame markers and frame numbers
`timescale 1ns/1ps
module ucr_host_model #(
    parameter int PERIOD = 1500,
    parameter logic [10:0] FIRST = 11'h5FE
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    output logic frame_mark,
    output logic [10:0] frame_number
);
    logic [15:0] gap_reg;
    // Marker low between frames; idle host sends nothing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_reg <= 16'h0000;
            frame_mark <= 1'h0;
        end else begin
            frame_mark <= run && (gap_reg < 16'h0004);
            if (!run || gap_reg == 16'(PERIOD - 1)) begin
                gap_reg <= 16'h0000;
            end else begin
                gap_reg <= gap_reg + 16'h0001;
            end
        end
    end
    // Start near a byte boundary so the high byte changes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_number <= FIRST;
        end else if (run && gap_reg == 16'(PERIOD - 1)) begin
            frame_number <= frame_number + 11'h001;
        end
    end
endmodule : ucr_host_model

// [verification/ucr_register_map_tb.sv]
// Self-checking bench for the indirect USB register map
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ucr_register_map_tb import ucr_pkg::*;;
    localparam int PERIOD = 1500;
    typedef struct packed {
        logic [5:0] a;
        logic [7:0] wd;
        logic [7:0] exp;
    } ucr_row_t;
    logic sys_clk, reset_n, addr_wr, data_wr, data_rd, speed, run;
    logic frame_mark, locked, full_speed, fifo_wr, fifo_rd, sel_valid;
    logic [7:0] addr_wd, data_wd, addr_rd, data_q, trim, fifo_wd;
    logic [7:0] wr_data, rv;
    logic [23:0] ev;
    logic [10:0] frame_no;
    logic [1:0] fifo_ep, sel_ep, wr_ep, rd_ep;
    int error_cnt, n_compared, n_wr, n_rd;
    logic [5:0] fa [3] = '{ADR_IN_FLAGS, ADR_OUT_FLAGS, ADR_CM_FLAGS};
    logic [7:0] cm [4] = '{8'h09, 8'h89, 8'hC9, 8'hA9};
    logic sp [4] = '{1'h1, 1'h1, 1'h1, 1'h0};
    // Three trims per enabled run: the first frame only arms the loop
    logic [7:0] tx [4] = '{8'h80, 8'h74, 8'h7D, 8'h74};
    ucr_row_t rows [15] = '{
        '{6'h00, 8'h5A, 8'h5A}, '{6'h01, 8'h0F, 8'h0F},
        '{6'h07, 8'h81, 8'h81}, '{6'h09, 8'h0E, 8'h0E},
        '{6'h0B, 8'h2C, 8'h2C}, '{6'h11, 8'h33, 8'h33},
        '{6'h12, 8'h44, 8'h44}, '{6'h13, 8'h55, 8'h55},
        '{6'h14, 8'h66, 8'h66}, '{6'h15, 8'h77, 8'h77},
        '{6'h16, 8'hFF, 8'h2A}, '{6'h17, 8'hFF, 8'hBE},
        '{6'h18, 8'hFF, 8'hEF}, '{6'h10, 8'hFF, 8'h00},
        '{6'h0E, 8'hF1, 8'h01}};

    ucr_register_map ucr_register_map_inst (
        .SYS_CLK(sys_clk), .RESET_N(reset_n), .ADDR_WR(addr_wr),
        .ADDR_WDATA(addr_wd), .DATA_WR(data_wr), .DATA_RD(data_rd),
        .DATA_WDATA(data_wd), .SPEED_SELECT(speed),
        .FRAME_MARK(frame_mark), .FRAME_NUMBER(frame_no),
        .IN_EVENTS(ev[7:0]), .OUT_EVENTS(ev[15:8]), .CM_EVENTS(ev[23:16]),
        .EP0_RX_COUNT(8'h2A), .OUT_RX_COUNT(16'hBEEF), .FIFO_RDATA(8'h3C),
        .ADDR_RDATA(addr_rd), .DATA_RDATA(data_q), .OSC_TRIM(trim),
        .RECOVERY_LOCKED(locked), .FULL_SPEED(full_speed),
        .FIFO_WR(fifo_wr), .FIFO_RD(fifo_rd), .FIFO_EP(fifo_ep),
        .FIFO_WDATA(fifo_wd), .SELECTED_EP(sel_ep),
        .SELECT_VALID(sel_valid));

    ucr_host_model #(.PERIOD(PERIOD)) ucr_host_model_inst (
        .clk(sys_clk), .rst_n(reset_n), .run(run),
        .frame_mark(frame_mark), .frame_number(frame_no));

    initial begin
        sys_clk = 1'h0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Strobes are single cycles, so count them as they pass
    always @(posedge sys_clk) begin
        if (fifo_wr === 1'h1) begin
            n_wr++;
            wr_ep = fifo_ep;
            wr_data = fifo_wd;
        end
        if (fifo_rd === 1'h1) begin
            n_rd++;
            rd_ep = fifo_ep;
        end
    end

    task automatic end_sim;
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    task automatic wait_idle;
        int i;
        i = 0;
        do begin
            @(posedge sys_clk);
            #1;
            i++;
        end while (addr_rd[ADR_BUSY_BIT] !== 1'h0 && i < 20);
        if (addr_rd[ADR_BUSY_BIT] !== 1'h0) begin
            error_cnt++;
            end_sim();
        end
    endtask : wait_idle

    // Settle time covers the two-cycle lag of the write
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr_wr <= 1'h1;
        addr_wd <= {2'h0, a};
        @(posedge sys_clk);
        addr_wr <= 1'h0;
        data_wr <= 1'h1;
        data_wd <= d;
        @(posedge sys_clk);
        data_wr <= 1'h0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic au,
            output logic [7:0] v);
        @(posedge sys_clk);
        addr_wr <= 1'h1;
        addr_wd <= {1'h1, au, a};
        @(posedge sys_clk);
        addr_wr <= 1'h0;
        wait_idle();
        v = data_q;
    endtask : rd

    task automatic do_reset;
        logic [7:0] v;
        @(posedge sys_clk);
        reset_n <= 1'h0;
        repeat (3) @(posedge sys_clk);
        #1;
        `CHK(trim, TRIM_MID)
        `CHK({sel_valid, sel_ep, addr_rd}, 11'h400)
        @(posedge sys_clk);
        reset_n <= 1'h1;
        rd(ADR_CLK_REC, 1'h0, v);
        `CHK(v, CLK_REC_RESET)
        rd(ADR_EP_SEL, 1'h0, v);
        `CHK(v, 8'h00)
    endtask : do_reset

    initial begin
        repeat (90000) @(posedge sys_clk);
        error_cnt++;
        end_sim();
    end

    initial begin
        error_cnt = 0;
        n_compared = 0;
        n_wr = 0;
        n_rd = 0;
        {reset_n, addr_wr, data_wr, data_rd, run} = 5'h00;
        {addr_wd, data_wd, ev} = 40'h0;
        speed = 1'h1;
        do_reset();
        run <= 1'h1;
        repeat (3 * PERIOD + 10) @(posedge sys_clk);
        run <= 1'h0;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].wd);
            rd(rows[i].a, 1'h0, rv);
            `CHK(rv, rows[i].exp)
        end
        rd(ADR_FRAME_LO, 1'h0, rv);
        `CHK(rv, frame_no[7:0])
        rd(ADR_FRAME_HI, 1'h0, rv);
        `CHK(rv, {5'h00, frame_no[10:8]})
        for (int k = 0; k < 3; k++) begin
            @(posedge sys_clk);
            ev[8 * k +: 8] <= 8'h07;
            @(posedge sys_clk);
            ev <= 24'h000000;
            rd(fa[k], 1'h0, rv);
            `CHK(rv, 8'h07)
            wr(fa[k], 8'h02);
            rd(fa[k], 1'h0, rv);
            `CHK(rv, 8'h05)
        end
        // Select first, then touch the indexed register
        for (int e = 1; e < 4; e++) begin
            wr(ADR_EP_SEL, 8'(e));
            `CHK({sel_valid, sel_ep}, {1'h1, 2'(e)})
            wr(ADR_OUT_CSR_LO, 8'h10 + 8'(e));
        end
        for (int e = 3; e > 0; e--) begin
            wr(ADR_EP_SEL, 8'(e));
            rd(ADR_OUT_CSR_LO, 1'h0, rv);
            `CHK(rv, 8'h10 + 8'(e))
        end
        wr(ADR_EP_SEL, 8'h04);
        `CHK(sel_valid, 1'h0)
        wr(ADR_OUT_CSR_LO, 8'hFF);
        rd(ADR_OUT_CSR_LO, 1'h0, rv);
        `CHK(rv, 8'h00)
        rd(ADR_EP_SEL, 1'h0, rv);
        `CHK(rv, 8'h04)
        wr(ADR_EP_SEL, 8'h03);
        rd(ADR_OUT_CSR_LO, 1'h0, rv);
        `CHK(rv, 8'h13)
        wr(ADR_FIFO_BASE + 6'h02, 8'hC3);
        `CHK({n_wr, wr_ep, wr_data}, {32'h1, 2'h2, 8'hC3})
        rd(ADR_FIFO_BASE + 6'h01, 1'h1, rv);
        `CHK(rv, 8'h3C)
        `CHK({n_rd, rd_ep, addr_rd}, {32'h1, 2'h1, 8'h61})
        @(posedge sys_clk);
        data_rd <= 1'h1;
        @(posedge sys_clk);
        data_rd <= 1'h0;
        wait_idle();
        `CHK({n_rd, rd_ep}, {32'h2, 2'h1})
        for (int m = 0; m < 4; m++) begin
            do_reset();
            @(posedge sys_clk);
            speed <= sp[m];
            repeat (6) @(posedge sys_clk);
            #1;
            `CHK(full_speed, sp[m])
            wr(ADR_CLK_REC, cm[m]);
            rd(ADR_CLK_REC, 1'h0, rv);
            `CHK(rv, cm[m])
            run <= 1'h1;
            repeat (4 * PERIOD) @(posedge sys_clk);
            run <= 1'h0;
            #1;
            `CHK({trim, locked}, {tx[m], 1'h0})
        end
        end_sim();
    end
endmodule : ucr_register_map_tb
